// [nand_id_readout.sv]
// Purpose: identification read-out of the flash command interface
// Assumes: host pins are asynchronous to mclk and strobes last several mclk periods
// Notes:   capability bytes are software-loaded through the register port
//
// The strobed register port and the register offsets were left to the implementer.
`default_nettype none
module nand_id_readout
  import id_readout_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // host pins
  input  wire logic        ce_n,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        we_n,
  input  wire logic        re_n,
  input  wire logic [7:0]  io_in,
  output logic      [7:0]  io_out,
  output logic             io_oe,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);
  logic        rst_m;
  logic        rst_sync_n;
  logic [12:0] pin_m;
  logic [12:0] pin_s;
  logic        we_prev;
  logic        re_prev;
  logic        wr_ev;
  logic        rd_ev;
  logic        cmd_ev;
  logic        addr_ev;
  logic        entry;
  logic        pop;
  cmd_state_t  state;
  logic [2:0]  prod_idx;
  logic [2:0]  rd_idx;
  logic [7:0]  maker;
  logic [7:0]  device;
  logic [7:0]  caps;
  logic [7:0]  geom;
  logic [7:0]  plane;
  logic        id_mode;
  logic        ce_s;
  logic        cle_s;
  logic        ale_s;
  logic        we_s;
  logic        re_s;
  logic [7:0]  io_s;

  id_fifo_if #(.WIDTH(8)) fq ();

  id_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk  (mclk),
    .rst_n (rst_sync_n),
    .port  (fq.store)
  );

  // byte of the sequence at a given position
  function automatic logic [7:0] id_byte(input logic [2:0] idx);
    unique case (idx)
      3'h0:    id_byte = maker;
      3'h1:    id_byte = device;
      3'h2:    id_byte = caps;
      3'h3:    id_byte = geom;
      3'h4:    id_byte = plane;
      default: id_byte = maker;
    endcase
  endfunction

  // wraps after the fifth byte, so the sixth read serves the maker again
  function automatic logic [2:0] idx_step(input logic [2:0] idx);
    idx_step = (idx == 3'(ID_BYTES - 1)) ? 3'h0 : idx + 3'h1;
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m      <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_m      <= 1'b1;
      rst_sync_n <= rst_m;
    end
  end

  // pin synchronisers; only pin_s is looked at by logic
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_m <= 13'h1F00;
      pin_s <= 13'h1F00;
    end else begin
      pin_m <= {re_n, we_n, ale, cle, ce_n, io_in};
      pin_s <= pin_m;
    end
  end

  assign {re_s, we_s, ale_s, cle_s, ce_s, io_s} = pin_s;

  // strobe history for edge detection
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      we_prev <= 1'b1;
      re_prev <= 1'b1;
    end else begin
      we_prev <= we_s;
      re_prev <= re_s;
    end
  end

  // data latch on write-enable rise, read cycle starts on read-enable fall
  assign wr_ev   = we_s & ~we_prev & ~ce_s;
  assign rd_ev   = ~re_s & re_prev & ~ce_s;
  assign cmd_ev  = wr_ev & cle_s & ~ale_s;
  assign addr_ev = wr_ev & ale_s & ~cle_s;
  assign id_mode = state == st_ident;
  assign entry   = (state == st_await_addr) & addr_ev & (io_s == ADDR_IDENT);

  // command decoder; any command leaves identification mode
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= st_idle;
    end else if (cmd_ev) begin
      state <= (io_s == CMD_IDENT) ? st_await_addr : st_idle;
    end else if (entry) begin
      state <= st_ident;
    end else if (addr_ev && state == st_await_addr) begin
      state <= st_idle;
    end
  end

  // decoder checks: only the command byte and then the right address may open identification mode
  chk_cmd_arms: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    cmd_ev && io_s == CMD_IDENT |=> state == st_await_addr)
    else $error("identification command did not arm the address wait");
  chk_cmd_other: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    cmd_ev && io_s != CMD_IDENT |=> state == st_idle)
    else $error("other command did not return to idle");
  chk_addr_wrong: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    state == st_await_addr && addr_ev && io_s != ADDR_IDENT |=> state == st_idle)
    else $error("wrong address entered identification mode");
  chk_await_hold: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    state == st_await_addr && !wr_ev |=> state == st_await_addr)
    else $error("address wait dropped without a latch");
  // an address byte on its own must never open the mode
  chk_idle_stays: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    state == st_idle && !cmd_ev |=> state == st_idle)
    else $error("idle left without a command");
  chk_mode_entry: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    $rose(id_mode) |-> $past(entry))
    else $error("identification mode entered without command and address");

  // producer: keeps the fifo topped up; stalls on full, which paces it
  assign fq.push_valid = id_mode;
  assign fq.push_data  = id_byte(prod_idx);
  assign fq.flush      = entry | cmd_ev;
  assign pop           = rd_ev & id_mode & fq.pop_valid;
  assign fq.pop_ready  = rd_ev & id_mode;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prod_idx <= 3'h0;
    end else if (fq.flush) begin
      prod_idx <= 3'h0;
    end else if (fq.push_valid && fq.push_ready) begin
      prod_idx <= idx_step(prod_idx);
    end
  end

  // the filler walks the ring one step per accepted byte; a full fifo must freeze it
  chk_fill_step: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    fq.push_valid && fq.push_ready && !fq.flush |=> prod_idx == idx_step($past(prod_idx)))
    else $error("filler skipped a byte");
  chk_fill_stall: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    fq.push_valid && !fq.push_ready && !fq.flush |=> $stable(prod_idx))
    else $error("filler moved while the fifo was full");
  chk_flush_empty: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    fq.flush |=> !fq.pop_valid && fq.level == 4'h0)
    else $error("fifo not emptied by a command");

  // read side: each read cycle in identification mode takes the next byte in order
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_idx <= 3'h0;
      io_out <= 8'h00;
    end else if (fq.flush) begin
      rd_idx <= 3'h0;
    end else if (pop) begin
      rd_idx <= idx_step(rd_idx);
      io_out <= fq.pop_data;
    end
  end

  // the served byte holds between reads, and reads outside the mode change nothing
  chk_out_holds: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    !pop |=> $stable(io_out))
    else $error("served byte changed without a read");
  chk_rd_step: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pop && !fq.flush |=> rd_idx == idx_step($past(rd_idx)))
    else $error("read pointer skipped a byte");
  chk_rd_ignored: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    rd_ev && !id_mode && !fq.flush |=> $stable(rd_idx) && $stable(io_out))
    else $error("read outside identification mode changed the pointer");
  // fifo head and read pointer must agree, or a stale byte would be served
  chk_pop_served: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pop |-> fq.pop_data == id_byte(rd_idx))
    else $error("fifo head out of step with the read pointer");

  // drive the bus only while a read strobe is low in identification mode
  assign io_oe = id_mode & ~ce_s & ~re_s;

  // capability registers; software loads field values at their byte positions
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      maker  <= MAKER_RST;
      device <= DEVICE_RST;
      caps   <= CAPS_RST;
      geom   <= GEOM_RST;
      plane  <= PLANE_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_MAKER:  maker  <= reg_wdata[7:0];
        REG_DEVICE: device <= reg_wdata[7:0];
        REG_CAPS:   caps   <= reg_wdata[7:0];
        REG_GEOM:   geom   <= reg_wdata[7:0];
        REG_PLANE:  plane  <= {1'b0, reg_wdata[6:0]};
        default:    ;
      endcase
    end
  end

  // the top bit of the fifth byte is kept low whatever software writes
  chk_plane_zero: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    reg_wr && reg_addr == REG_PLANE |=> !plane[PLANE_ZERO] && plane[6:0] == $past(reg_wdata[6:0]))
    else $error("fifth byte top bit not held low");

  // register read, answer in the following cycle, unmapped reads zero
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_MAKER:  reg_rdata <= {24'h00_0000, maker};
        REG_DEVICE: reg_rdata <= {24'h00_0000, device};
        REG_CAPS:   reg_rdata <= {24'h00_0000, caps};
        REG_GEOM:   reg_rdata <= {24'h00_0000, geom};
        REG_PLANE:  reg_rdata <= {24'h00_0000, plane};
        REG_STATUS: reg_rdata <= {23'h00_0000, rd_idx, state == st_await_addr, id_mode, fq.level};
        default:    reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // checks
  chk_entry_mode: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    entry |=> id_mode && rd_idx == 3'h0)
    else $error("identification entry did not take effect");
  chk_byte_order: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pop |=> io_out == id_byte($past(rd_idx)))
    else $error("identification byte out of order");
  chk_mode_holds: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    id_mode && !cmd_ev |=> id_mode)
    else $error("identification mode left without a command");
  chk_mode_leaves: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    id_mode && cmd_ev |=> !id_mode ##1 !io_oe)
    else $error("identification mode kept after a command");
  chk_sixth_wrap: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pop && rd_idx == 3'h4 |=> rd_idx == 3'h0 && io_out == plane)
    else $error("sequence did not wrap after fifth byte");
  chk_third_low: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pop && rd_idx == 3'h2 |=> io_out[3:0] == {caps[CAPS_CELL_LO+:2], caps[CAPS_CHIPS_LO+:2]})
    else $error("third byte chip or cell field wrong");
  chk_third_high: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pop && rd_idx == 3'h2 |=> io_out[7:4] == {caps[CAPS_CACHE], caps[CAPS_ILEAVE], caps[CAPS_PAGES_LO+:2]})
    else $error("third byte program fields wrong");
  chk_fourth_size: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pop && rd_idx == 3'h3 |=> io_out[1:0] == geom[GEOM_PAGE_LO+:2] && io_out[5:4] == geom[GEOM_BLOCK_LO+:2])
    else $error("fourth byte size fields wrong");
  chk_fourth_misc: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pop && rd_idx == 3'h3 |=> {io_out[7], io_out[6], io_out[3], io_out[2]} ==
      {geom[GEOM_ACC_HI], geom[GEOM_WIDTH], geom[GEOM_ACC_LO], geom[GEOM_SPARE]})
    else $error("fourth byte access or width fields wrong");
  chk_fifth_top: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pop && rd_idx == 3'h4 |=> io_out[PLANE_ZERO] == 1'b0 && io_out[6:0] == plane[6:0])
    else $error("fifth byte wrong");
  chk_restart_ptr: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    entry |=> prod_idx == 3'h0 && fq.push_valid && fq.push_data == maker)
    else $error("pointer not restarted on reentry");
endmodule
`default_nettype wire

// [id_readout_pkg.sv]
// Purpose: shared constants for the identification read-out block
// Assumes: one clock (mclk, 200 MHz), active-low asynchronous reset
// Notes:   register offsets are word indices on the plain register port
// Operation
// - command 90h then address 00h switches read data to identification bytes
// - five reads give maker, device, then third, fourth, fifth bytes in order
// - identification mode holds, serving bytes, until the host writes another command
// - a sixth read returns the maker byte again; later content is not relied on
// - third byte bits 1:0 give chip count, bits 3:2 give cell type
// - third byte bits 5:4 pages, bit 6 interleave, bit 7 cache program
// - fourth byte bits 1:0 page size, bits 5:4 block size
// - fourth byte bit 2 spare size, bit 6 width, bits 7 and 3 access time
// - fifth byte bits 3:2 planes, 6:4 plane size, 1:0 process, bit 7 zero
`default_nettype none
package id_readout_pkg;
  // host command and address codes, sequence length and fifo depth
  localparam logic [7:0] CMD_IDENT  = 8'h90;
  localparam logic [7:0] ADDR_IDENT = 8'h00;
  localparam int unsigned ID_BYTES  = 5;
  localparam int unsigned FIFO_DEPTH = 8;

  // register indices
  localparam logic [3:0] REG_MAKER  = 4'h0;
  localparam logic [3:0] REG_DEVICE = 4'h1;
  localparam logic [3:0] REG_CAPS   = 4'h2;
  localparam logic [3:0] REG_GEOM   = 4'h3;
  localparam logic [3:0] REG_PLANE  = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;

  // reset values; maker and device values are arbitrary
  localparam logic [7:0] MAKER_RST  = 8'h3A;
  localparam logic [7:0] DEVICE_RST = 8'h5C;
  localparam logic [7:0] CAPS_RST   = 8'h00;
  localparam logic [7:0] GEOM_RST   = 8'h01;
  localparam logic [7:0] PLANE_RST  = 8'h00;

  // field positions of the capability bytes
  localparam int unsigned CAPS_CHIPS_LO = 0;
  localparam int unsigned CAPS_CELL_LO  = 2;
  localparam int unsigned CAPS_PAGES_LO = 4;
  localparam int unsigned CAPS_ILEAVE   = 6;
  localparam int unsigned CAPS_CACHE    = 7;
  localparam int unsigned GEOM_PAGE_LO  = 0;
  localparam int unsigned GEOM_SPARE    = 2;
  localparam int unsigned GEOM_ACC_LO   = 3;
  localparam int unsigned GEOM_BLOCK_LO = 4;
  localparam int unsigned GEOM_WIDTH    = 6;
  localparam int unsigned GEOM_ACC_HI   = 7;
  localparam int unsigned PLANE_PROC_LO = 0;
  localparam int unsigned PLANE_NUM_LO  = 2;
  localparam int unsigned PLANE_SIZE_LO = 4;
  localparam int unsigned PLANE_ZERO    = 7;

  // status register fields
  localparam int unsigned STAT_LEVEL_LO = 0;
  localparam int unsigned STAT_MODE     = 4;
  localparam int unsigned STAT_AWAIT    = 5;
  localparam int unsigned STAT_IDX_LO   = 6;

  typedef enum logic [1:0] {st_idle, st_await_addr, st_ident} cmd_state_t;
endpackage
`default_nettype wire

// [id_fifo_if.sv]
// Purpose: carrier between the read-out sequencer and its byte fifo
// Assumes: both ends on mclk
// Notes:   flush empties the store in one cycle
`default_nettype none
interface id_fifo_if #(parameter int unsigned WIDTH = 8) ();
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic             flush;
  logic [3:0]       level;

  modport filler (output push_valid, push_data, pop_ready, flush,
                  input  push_ready, pop_valid, pop_data, level);
  modport store  (input  push_valid, push_data, pop_ready, flush,
                  output push_ready, pop_valid, pop_data, level);
endinterface
`default_nettype wire

// [id_byte_fifo.sv]
// Purpose: small synchronous fifo holding pending identification bytes
// Assumes: DEPTH is a power of two, at most 8
// Notes:   pop data come from the head register of the store
`default_nettype none
module id_byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  id_fifo_if.store  port
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             do_push;
  logic             do_pop;

  // full when pointers differ only in the wrap bit
  assign port.push_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign port.pop_valid  = wr_ptr != rd_ptr;
  assign do_push         = port.push_valid & port.push_ready & ~port.flush;
  assign do_pop          = port.pop_valid & port.pop_ready & ~port.flush;
  assign port.pop_data   = mem[rd_ptr[AW-1:0]];
  assign port.level      = 4'((wr_ptr - rd_ptr));

  // storage, no reset needed on the data words
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wr_ptr[AW-1:0]] <= port.push_data;
    end
  end

  // pointers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (port.flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [nand_host_model.sv]
// Purpose: behavioural host flash controller that drives the command and read strobes
// Assumes: write strobe phases last 4 mclk periods, twice the minimum the block needs; read strobe phases last 5
// Notes:   a released io bus shows the inverse of the last byte, so stale data never passes
`default_nettype none
module nand_host_model (
  input  wire logic       mclk,
  output logic            ce_n,
  output logic            cle,
  output logic            ale,
  output logic            we_n,
  output logic            re_n,
  output logic      [7:0] io_in,
  input  wire logic [7:0] io_out,
  input  wire logic       io_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle pins at time zero
  initial begin
    ce_n  = 1'b1;
    cle   = 1'b0;
    ale   = 1'b0;
    we_n  = 1'b1;
    re_n  = 1'b1;
    io_in = 8'h00;
  end

  // one command (is_cmd) or address byte, latched on the rising write strobe
  task automatic latch(input logic is_cmd, input logic [7:0] b);
    @(posedge mclk);
    ce_n  <= 1'b0;
    cle   <= is_cmd;
    ale   <= !is_cmd;
    io_in <= b;
    we_n  <= 1'b0;
    repeat (4) @(posedge mclk);
    we_n  <= 1'b1;
    repeat (4) @(posedge mclk);
    cle   <= 1'b0;
    ale   <= 1'b0;
    io_in <= ~b; // released bus, no longer the last byte
    repeat (4) @(posedge mclk);
  endtask

  // one read cycle; samples the byte and the enable while the strobe is low
  task automatic read_byte(output logic [7:0] d, output logic oe);
    @(posedge mclk);
    re_n <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    d  = io_out;
    oe = io_oe;
    re_n <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// [nand_id_readout_tb.sv]
// Purpose: self-checking bench for the identification read-out block
// Assumes: host pins come from the host model, registers from this bench
// Notes:   every expected byte is built here from the chosen field codes
`default_nettype none
module nand_id_readout_tb;
  import id_readout_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk;
  logic        rst_n;
  logic        ce_n;
  logic        cle;
  logic        ale;
  logic        we_n;
  logic        re_n;
  logic [7:0]  io_in;
  logic [7:0]  io_out;
  logic        io_oe;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  int          err_total;
  int          n_tests;
  logic [7:0]  exp_id [5];

  nand_id_readout dut (.mclk(mclk), .rst_n(rst_n), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .re_n(re_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  nand_host_model host (.mclk(mclk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe));

  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      err_total++;
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic enter_ident(input logic [7:0] addr);
    host.latch(1'b1, CMD_IDENT);
    host.latch(1'b0, addr);
  endtask

  // reads n bytes starting at ring position first and compares each
  task automatic read_seq(input int first, input int n, input string msg);
    logic [7:0] d;
    logic       oe;
    for (int i = 0; i < n; i++) begin
      host.read_byte(d, oe);
      chk(32'(oe), 32'h1, msg);
      chk(32'(d), 32'(exp_id[(first + i) % 5]), msg);
    end
  endtask

  task automatic t_reset;
    logic [31:0] d;
    reg_read(REG_MAKER, d);
    chk(d, 32'(MAKER_RST), "maker reset");
    @(posedge mclk);
    #1;
    chk(reg_rdata, 32'h0, "read data after its cycle");
    reg_read(REG_GEOM, d);
    chk(d, 32'(GEOM_RST), "geom reset");
    reg_read(4'hF, d);
    chk(d, 32'h0, "unmapped read");
    reg_read(REG_STATUS, d);
    chk(32'(d[STAT_MODE]), 32'h0, "mode after reset");
    $display("test reset done");
  endtask

  // fields chosen to set every kind of code once: E5h, 96h, plane F6h with bit 7 forced low
  task automatic t_ident;
    logic [31:0] d;
    exp_id = '{8'hA7, 8'h4B, 8'hE5, 8'h96, 8'h76};
    reg_write(REG_MAKER, 32'h0000_00A7);
    reg_write(REG_DEVICE, 32'h0000_004B);
    reg_write(REG_CAPS, 32'h0000_00E5);
    reg_write(REG_GEOM, 32'h0000_0096);
    reg_write(REG_PLANE, 32'h0000_00F6);
    enter_ident(ADDR_IDENT);
    reg_read(REG_STATUS, d);
    chk(32'(d[STAT_MODE]), 32'h1, "mode after entry");
    read_seq(0, 7, "id sequence");
    $display("test ident done");
  endtask

  task automatic t_restart;
    read_seq(2, 2, "before restart");
    enter_ident(ADDR_IDENT);
    read_seq(0, 2, "after restart");
    $display("test restart done");
  endtask

  task automatic t_leave;
    logic [7:0]  b;
    logic        oe;
    logic [31:0] d;
    host.latch(1'b1, 8'hFF);
    host.read_byte(b, oe);
    chk(32'(oe), 32'h0, "read after other command");
    host.latch(1'b1, CMD_IDENT);
    reg_read(REG_STATUS, d);
    chk(32'(d[STAT_AWAIT]), 32'h1, "waiting for address");
    host.latch(1'b0, 8'h01);
    host.read_byte(b, oe);
    chk(32'(oe), 32'h0, "read after wrong address");
    reg_read(REG_STATUS, d);
    chk(32'(d[STAT_MODE]), 32'h0, "mode after wrong address");
    enter_ident(ADDR_IDENT);
    read_seq(0, 1, "re-entry");
    $display("test leave done");
  endtask

  task automatic stop_test;
    $display("tests %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence; reset held for 8 cycles, then the synchroniser settles
  initial begin
    err_total = 0;
    n_tests   = 0;
    rst_n     = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    t_reset;
    t_ident;
    t_restart;
    t_leave;
    stop_test;
  end

  // the tests need well under 2000 cycles; ten times that means a hang
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    stop_test;
  end
endmodule
`default_nettype wire
